// ==== pkg/cwt_regs.svh ====
`ifndef CWT_REGS_SVH
`define CWT_REGS_SVH

// clock and timebase
`define CWT_CLK_PERIOD_NS 32'h0000_0064
`define CWT_TICK_TIME_NS 32'h0001_86a0
`define CWT_TICK_CYCLES ((`CWT_TICK_TIME_NS + `CWT_CLK_PERIOD_NS - 32'h0000_0001) / `CWT_CLK_PERIOD_NS)

// period select codes
`define CWT_PER_10MS 3'h0
`define CWT_PER_20MS 3'h1
`define CWT_PER_50MS 3'h2
`define CWT_PER_100MS 3'h3
`define CWT_PER_200MS 3'h4
`define CWT_PER_1S 3'h5
`define CWT_PER_2S 3'h6

// period lengths in 0.1 ms ticks
`define CWT_PER_10MS_TICKS 15'h0064
`define CWT_PER_20MS_TICKS 15'h00c8
`define CWT_PER_50MS_TICKS 15'h01f4
`define CWT_PER_100MS_TICKS 15'h03e8
`define CWT_PER_200MS_TICKS 15'h07d0
`define CWT_PER_1S_TICKS 15'h2710
`define CWT_PER_2S_TICKS 15'h4e20

// on-time select codes
`define CWT_ON_OFF_LOW 3'h0
`define CWT_ON_100US 3'h1
`define CWT_ON_300US 3'h2
`define CWT_ON_1MS 3'h3
`define CWT_ON_10MS 3'h4
`define CWT_ON_20MS 3'h5
`define CWT_ON_OFF_HIGH 3'h6

// on-time lengths in 0.1 ms ticks
`define CWT_ON_100US_TICKS 15'h0001
`define CWT_ON_300US_TICKS 15'h0003
`define CWT_ON_1MS_TICKS 15'h000a
`define CWT_ON_10MS_TICKS 15'h0064
`define CWT_ON_20MS_TICKS 15'h00c8

// high-side map select codes
`define CWT_MAP_NONE 2'h0
`define CWT_MAP_TIMER_A 2'h1
`define CWT_MAP_TIMER_B 2'h2

// reset values
`define CWT_CNT_RST 15'h0000
`define CWT_TICK_RST 10'h000

`endif

// ==== pkg/cwt_pkg.sv ====
package cwt_pkg;
`include "cwt_regs.svh"

    // timer phase
    typedef enum logic [1:0] {TMR_IDLE, TMR_ON, TMR_OFF} timer_state_type;

    // period code to tick count, unknown code runs as the longest
    // seven period lengths
    function automatic logic [14:0] period_ticks(input logic [2:0] code);
        unique case (code)
            `CWT_PER_10MS: period_ticks = `CWT_PER_10MS_TICKS;
            `CWT_PER_20MS: period_ticks = `CWT_PER_20MS_TICKS;
            `CWT_PER_50MS: period_ticks = `CWT_PER_50MS_TICKS;
            `CWT_PER_100MS: period_ticks = `CWT_PER_100MS_TICKS;
            `CWT_PER_200MS: period_ticks = `CWT_PER_200MS_TICKS;
            `CWT_PER_1S: period_ticks = `CWT_PER_1S_TICKS;
            default: period_ticks = `CWT_PER_2S_TICKS;
        endcase
    endfunction : period_ticks

    // on-time code to tick count, stopped codes give zero
    // five on-times, two stops
    function automatic logic [14:0] on_ticks(input logic [2:0] code);
        unique case (code)
            `CWT_ON_100US: on_ticks = `CWT_ON_100US_TICKS;
            `CWT_ON_300US: on_ticks = `CWT_ON_300US_TICKS;
            `CWT_ON_1MS: on_ticks = `CWT_ON_1MS_TICKS;
            `CWT_ON_10MS: on_ticks = `CWT_ON_10MS_TICKS;
            `CWT_ON_20MS: on_ticks = `CWT_ON_20MS_TICKS;
            default: on_ticks = `CWT_CNT_RST;
        endcase
    endfunction : on_ticks

    // true for codes that run the timer
    function automatic logic on_active(input logic [2:0] code);
        on_active = (on_ticks(code) != `CWT_CNT_RST);
    endfunction : on_active

endpackage : cwt_pkg

// ==== pkg/timer_if.sv ====
`timescale 1ns/1ps
interface timer_if;
    logic tick; // 0.1 ms enable pulse
    logic load; // setup write strobe
    logic [2:0] period_sel; // period code
    logic [2:0] on_sel; // on-time code
    logic running; // timer cycling
    logic on_phase; // inside on-time
    logic on_start; // on-time began, not the first
    logic level; // drive level for mapped switches

    modport ctl (output tick, load, period_sel, on_sel,
        input running, on_phase, on_start, level);
    modport tmr (input tick, load, period_sel, on_sel,
        output running, on_phase, on_start, level);
endinterface : timer_if

// ==== logic/periodic_timer.sv ====
`timescale 1ns/1ps
module periodic_timer
    import cwt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // control side
    timer_if.tmr bus
);

    timer_state_type state_reg, state_next; // phase
    logic [14:0] cnt_reg, cnt_next; // ticks into period
    logic [2:0] per_reg, per_next; // period code
    logic [2:0] on_reg, on_next; // on-time code
    logic start_reg, start_next; // on-time start pulse
    logic high_reg, high_next; // stopped level
    logic [14:0] cnt_inc; // counter plus one

    // next-state logic
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        per_next = per_reg;
        on_next = on_reg;
        start_next = 1'b0;
        high_next = high_reg;
        cnt_inc = 15'(cnt_reg + 15'h0001);
        if (bus.load) begin
            per_next = bus.period_sel;
            on_next = bus.on_sel;
            cnt_next = `CWT_CNT_RST;
            high_next = (bus.on_sel == `CWT_ON_OFF_HIGH);
            if (on_active(bus.on_sel)) begin
                state_next = TMR_ON;
            end else begin
                state_next = TMR_IDLE;
            end
        end else if (bus.tick && state_reg != TMR_IDLE) begin
            if (cnt_inc >= period_ticks(per_reg)) begin
                cnt_next = `CWT_CNT_RST;
                state_next = TMR_ON;
                start_next = 1'b1;
            end else begin
                cnt_next = cnt_inc;
                if (state_reg == TMR_ON && cnt_inc >= on_ticks(on_reg)) begin
                    state_next = TMR_OFF;
                end
            end
        end
    end

    // registers only
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg <= TMR_IDLE;
            cnt_reg <= `CWT_CNT_RST;
            per_reg <= `CWT_PER_10MS;
            on_reg <= `CWT_ON_OFF_LOW;
            start_reg <= 1'b0;
            high_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            per_reg <= per_next;
            on_reg <= on_next;
            start_reg <= start_next;
            high_reg <= high_next;
        end
    end

    // status toward the controller
    assign bus.running = (state_reg != TMR_IDLE);
    assign bus.on_phase = (state_reg == TMR_ON);
    assign bus.on_start = start_reg;
    assign bus.level = bus.running ? bus.on_phase : high_reg;

    // no interrupt pulse right after a start
    property p_first_silent;
        @(posedge clk_sys) disable iff (!nrst)
        bus.load |=> !bus.on_start;
    endproperty
    a_first_silent: assert property (p_first_silent) else $error("first on-time pulsed");

    // an active on-time write starts the on phase
    property p_load_starts;
        @(posedge clk_sys) disable iff (!nrst)
        bus.load && on_active(bus.on_sel) |=> bus.on_phase && bus.running;
    endproperty
    a_load_starts: assert property (p_load_starts) else $error("timer did not start");

    // stopped code never runs, level follows the code
    property p_stopped;
        @(posedge clk_sys) disable iff (!nrst)
        bus.load && !on_active(bus.on_sel)
            |=> !bus.running && bus.level == ($past(bus.on_sel) == `CWT_ON_OFF_HIGH);
    endproperty
    a_stopped: assert property (p_stopped) else $error("stopped timer misbehaves");

    // a period start always opens the on phase
    property p_start_on;
        @(posedge clk_sys) disable iff (!nrst)
        bus.on_start |-> bus.on_phase;
    endproperty
    a_start_on: assert property (p_start_on) else $error("start outside on-time");

endmodule : periodic_timer

// ==== logic/cyclic_wake_timer.sv ====
`timescale 1ns/1ps
module cyclic_wake_timer
    import cwt_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // device mode
    input wire logic mode_active,
    // timer setup writes, bit 0 timer a, bit 1 timer b
    input wire logic [1:0] timer_setup_wr,
    input wire logic [2:0] setup_period,
    input wire logic [2:0] setup_on_time,
    // wake source enables and switch mapping
    input wire logic [1:0] wake_source_control,
    input wire logic [3:0] high_side_map_first,
    input wire logic [3:0] high_side_map_second,
    // switch protection
    input wire logic [3:0] high_side_fault,
    // status clears
    input wire logic [1:0] wake_flag_clear,
    input wire logic spi_error_clear,
    // outputs
    output logic [3:0] high_side_switch,
    output logic [1:0] timer_running,
    output logic [1:0] wake_flag,
    output logic spi_error_flag,
    output logic int_n
);

    localparam logic [9:0] TICK_LAST = 10'(`CWT_TICK_CYCLES - 32'h0000_0001);

    timer_if tif[2] (); // one carrier per timer

    logic [9:0] tick_cnt_reg, tick_cnt_next; // timebase divider
    logic tick_reg, tick_next; // 0.1 ms enable
    logic [1:0] wake_flag_reg, wake_flag_next; // sticky wake status
    logic err_reg, err_next; // sticky setup error
    logic int_n_reg, int_n_next; // interrupt line
    logic [3:0] hs_reg, hs_next; // switch drive
    logic [1:0] on_start_vec; // per-timer start pulses
    logic [1:0] level_vec; // per-timer drive levels
    logic [7:0] map_all; // both map registers
    logic err_hit; // setup error this cycle

    // map select decode for one switch
    function automatic logic switch_level(input logic [1:0] sel, input logic [1:0] lvl);
        unique case (sel)
            `CWT_MAP_TIMER_A: switch_level = lvl[0];
            `CWT_MAP_TIMER_B: switch_level = lvl[1];
            default: switch_level = 1'b0;
        endcase
    endfunction : switch_level

    // timers, each loaded by its own setup strobe
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            assign tif[gi].tick = tick_reg;
            assign tif[gi].load = timer_setup_wr[gi];
            assign tif[gi].period_sel = setup_period;
            assign tif[gi].on_sel = setup_on_time;
            assign on_start_vec[gi] = tif[gi].on_start;
            assign level_vec[gi] = tif[gi].level;
            assign timer_running[gi] = tif[gi].running;
            periodic_timer u_tmr (
                .clk_sys(clk_sys),
                .nrst(nrst),
                .bus(tif[gi])
            );
        end
    endgenerate

    assign map_all = {high_side_map_second, high_side_map_first};

    // divider: the timers count in 0.1 ms steps
    always_comb begin
        tick_next = 1'b0;
        tick_cnt_next = 10'(tick_cnt_reg + 10'h001);
        if (tick_cnt_reg == TICK_LAST) begin
            tick_cnt_next = `CWT_TICK_RST;
            tick_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            tick_cnt_reg <= `CWT_TICK_RST;
            tick_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_cnt_next;
            tick_reg <= tick_next;
        end
    end

    // status flags and interrupt line
    always_comb begin
        // on-time longer than period
        // error check only on a running code; stopped codes have no length
        err_hit = 1'b0;
        if (|timer_setup_wr && on_active(setup_on_time)
                && on_ticks(setup_on_time) > period_ticks(setup_period)) begin
            err_hit = 1'b1;
        end
        // set wins over clear so no event is lost
        err_next = (err_reg && !spi_error_clear) || err_hit;
        // only in normal or stop mode
        wake_flag_next = (wake_flag_reg & ~wake_flag_clear)
            | (on_start_vec & wake_source_control & {2{mode_active}});
        int_n_next = ~|wake_flag_next;
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wake_flag_reg <= 2'h0;
            err_reg <= 1'b0;
            int_n_reg <= 1'b1;
        end else begin
            wake_flag_reg <= wake_flag_next;
            err_reg <= err_next;
            int_n_reg <= int_n_next;
        end
    end

    // switch drive; a fault blanks the switch but not its timer
    always_comb begin
        hs_next = 4'h0;
        for (int i = 0; i < 4; i++) begin
            hs_next[i] = switch_level(map_all[2*i +: 2], level_vec) && !high_side_fault[i];
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            hs_reg <= 4'h0;
        end else begin
            hs_reg <= hs_next;
        end
    end

    assign high_side_switch = hs_reg;
    assign wake_flag = wake_flag_reg;
    assign spi_error_flag = err_reg;
    assign int_n = int_n_reg;

    // a counted start on an enabled timer sets its flag
    property p_wake_set;
        @(posedge clk_sys) disable iff (!nrst)
        tif[0].on_start && wake_source_control[0] && mode_active |=> wake_flag[0] && !int_n;
    endproperty
    a_wake_set: assert property (p_wake_set) else $error("wake flag not raised");

    // disabled source never flags
    property p_wake_gate;
        @(posedge clk_sys) disable iff (!nrst)
        !wake_flag[1] && !(tif[1].on_start && wake_source_control[1]) |=> !wake_flag[1];
    endproperty
    a_wake_gate: assert property (p_wake_gate) else $error("flag without source");

    // sticky flag holds without a clear
    sequence s_flag_held;
        wake_flag[0] && !wake_flag_clear[0];
    endsequence
    property p_flag_sticky;
        @(posedge clk_sys) disable iff (!nrst)
        s_flag_held |=> wake_flag[0];
    endproperty
    a_flag_sticky: assert property (p_flag_sticky) else $error("wake flag dropped");

    // interrupt line mirrors the flags
    property p_int_line;
        @(posedge clk_sys) disable iff (!nrst)
        int_n == !(|wake_flag);
    endproperty
    a_int_line: assert property (p_int_line) else $error("int line mismatch");

    // long on-time write flags an error
    property p_err_set;
        @(posedge clk_sys) disable iff (!nrst)
        timer_setup_wr[0] && setup_on_time == `CWT_ON_20MS && setup_period == `CWT_PER_10MS
            |=> spi_error_flag;
    endproperty
    a_err_set: assert property (p_err_set) else $error("error flag not set");

    // fault on a switch fed by timer b keeps that timer running
    property p_fault_run;
        @(posedge clk_sys) disable iff (!nrst)
        high_side_fault[3] && tif[1].running && !timer_setup_wr[1] |=> tif[1].running;
    endproperty
    a_fault_run: assert property (p_fault_run) else $error("fault stopped timer");

    // switch 0 on timer a follows its level
    property p_switch_map;
        @(posedge clk_sys) disable iff (!nrst)
        high_side_map_first[1:0] == `CWT_MAP_TIMER_A && !high_side_fault[0]
            |=> high_side_switch[0] == $past(tif[0].level);
    endproperty
    a_switch_map: assert property (p_switch_map) else $error("switch map wrong");

endmodule : cyclic_wake_timer

// ==== testbench/host_model.sv ====
`timescale 1ns/1ps
// host side: answers the interrupt line by clearing the wake flags
module host_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic nrst,
    // interrupt and status from the device
    input wire logic int_n,
    input wire logic [1:0] wake_flag,
    // bench control, low holds the host busy so flags must stay latched
    input wire logic service_en,
    // clear request back to the device
    output logic [1:0] wake_flag_clear
);
    int wait_cnt; // service latency counter

    // host clears flag
    // a few cycles of latency, as a real handler would take
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            wait_cnt <= 0;
            wake_flag_clear <= 2'h0;
        end else if (service_en && int_n === 1'b0 && wait_cnt < 4) begin
            wait_cnt <= wait_cnt + 1;
            wake_flag_clear <= 2'h0;
        end else if (service_en && int_n === 1'b0) begin
            // one-cycle pulse on the flags seen set
            wait_cnt <= 0;
            wake_flag_clear <= wake_flag;
        end else begin
            wait_cnt <= 0;
            wake_flag_clear <= 2'h0;
        end
    end
endmodule : host_model

// ==== testbench/cyclic_wake_timer_test.sv ====
`timescale 1ns/1ps
module cyclic_wake_timer_test;
    import cwt_pkg::*;
    logic clk_sys = 1'b0; // 10 MHz system clock
    logic nrst = 1'b0; // async reset, active low
    logic mode_active = 1'b1; // normal or stop mode
    logic [1:0] timer_setup_wr = 2'h0;
    logic [2:0] setup_period = 3'h0;
    logic [2:0] setup_on_time = 3'h0;
    logic [1:0] wake_source_control = 2'h0;
    logic [3:0] high_side_map_first = 4'h0;
    logic [3:0] high_side_map_second = 4'h0;
    logic [3:0] high_side_fault = 4'h0;
    logic [1:0] wake_flag_clear;
    logic spi_error_clear = 1'b0;
    logic service_en = 1'b0; // host handler enable
    logic [3:0] high_side_switch;
    logic [1:0] timer_running;
    logic [1:0] wake_flag;
    logic spi_error_flag;
    logic int_n;
    int mismatches = 0;
    int comparisons = 0;

    // clock generation
    always #50 clk_sys = ~clk_sys;

    cyclic_wake_timer dut_u (.clk_sys(clk_sys), .nrst(nrst), .mode_active(mode_active),
        .timer_setup_wr(timer_setup_wr), .setup_period(setup_period),
        .setup_on_time(setup_on_time), .wake_source_control(wake_source_control),
        .high_side_map_first(high_side_map_first), .high_side_map_second(high_side_map_second),
        .high_side_fault(high_side_fault), .wake_flag_clear(wake_flag_clear),
        .spi_error_clear(spi_error_clear), .high_side_switch(high_side_switch),
        .timer_running(timer_running), .wake_flag(wake_flag),
        .spi_error_flag(spi_error_flag), .int_n(int_n));

    host_model host_u (.clk_sys(clk_sys), .nrst(nrst), .int_n(int_n),
        .wake_flag(wake_flag), .service_en(service_en), .wake_flag_clear(wake_flag_clear));

    // compare and count
    task automatic check(input string name, input logic [3:0] exp, input logic [3:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask : check

    // one setup write; returns just after the taking edge has landed
    task automatic write_setup(input logic [1:0] mask, input logic [2:0] per,
        input logic [2:0] on);
        @(posedge clk_sys);
        timer_setup_wr <= mask;
        setup_period <= per;
        setup_on_time <= on;
        @(posedge clk_sys);
        timer_setup_wr <= 2'h0;
        #1;
    endtask : write_setup

    // verdict, the single exit point
    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : finish_test

    // stopped codes give a static level and no running
    task automatic test_static_levels;
        logic [2:0] codes [3];
        logic [3:0] lvl [3];
        codes = '{`CWT_ON_OFF_HIGH, `CWT_ON_OFF_LOW, 3'h7};
        lvl = '{4'h1, 4'h0, 4'h0};
        foreach (codes[i]) begin
            write_setup(2'b01, `CWT_PER_10MS, codes[i]);
            check("running_static", 4'h0, {2'h0, timer_running});
            @(posedge clk_sys);
            #1;
            check("switch_static", lvl[i], high_side_switch);
        end
    endtask : test_static_levels

    // on-time longer than period raises a sticky error
    task automatic test_error_flag;
        write_setup(2'b01, `CWT_PER_10MS, `CWT_ON_20MS);
        check("error_set", 4'h1, {3'h0, spi_error_flag});
        repeat (5) @(posedge clk_sys);
        spi_error_clear <= 1'b1;
        @(posedge clk_sys);
        spi_error_clear <= 1'b0;
        #1;
        check("error_clear", 4'h0, {3'h0, spi_error_flag});
        // equal on-time and period is legal, so the longer period must decode right
        write_setup(2'h1, `CWT_PER_20MS, `CWT_ON_20MS);
        check("error_equal_period", 4'h0, {3'h0, spi_error_flag});
        write_setup(2'b11, `CWT_PER_10MS, `CWT_ON_OFF_LOW);
        check("error_quiet", 4'h0, {3'h0, spi_error_flag});
    endtask : test_error_flag

    // full cyclic wake: start, first on phase silent, second raises flag
    task automatic test_cyclic_wake;
        int n;
        @(posedge clk_sys);
        wake_source_control <= 2'h1;
        write_setup(2'h3, `CWT_PER_10MS, `CWT_ON_100US);
        check("running_start", 4'h3, {2'h0, timer_running});
        @(posedge clk_sys);
        #1;
        // switch 3 faulted, stays off
        check("switch_on_phase", 4'h5, high_side_switch);
        repeat (1100) @(posedge clk_sys);
        #1;
        check("switch_off_phase", 4'h0, high_side_switch);
        check("no_first_flag", 4'h1, {1'h0, wake_flag, int_n});
        n = 0;
        while (int_n !== 1'b0 && n < 101000) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("wake_flag_set", 4'h1, {2'h0, wake_flag});
        check("int_low", 4'h0, {3'h0, int_n});
        @(posedge clk_sys);
        #1;
        check("switch_again", 4'h5, high_side_switch);
        check("running_fault", 4'h3, {2'h0, timer_running});
        repeat (20) @(posedge clk_sys);
        #1;
        check("flag_sticky", 4'h1, {2'h0, wake_flag});
        service_en <= 1'b1;
        n = 0;
        while (int_n !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            #1;
            n++;
        end
        check("flag_cleared", 4'h1, {1'h0, wake_flag, int_n});
        write_setup(2'b11, `CWT_PER_10MS, `CWT_ON_OFF_LOW);
        check("running_stop", 4'h0, {2'h0, timer_running});
    endtask : test_cyclic_wake

    // main sequence
    initial begin
        repeat (4) @(posedge clk_sys);
        nrst <= 1'b1;
        high_side_map_first <= {`CWT_MAP_NONE, `CWT_MAP_TIMER_A};
        high_side_map_second <= {`CWT_MAP_TIMER_B, `CWT_MAP_TIMER_B};
        high_side_fault <= 4'h8;
        #1;
        check("reset_out", 4'h1, {spi_error_flag, wake_flag, int_n});
        test_static_levels();
        test_error_flag();
        test_cyclic_wake();
        finish_test();
    end

    // watchdog, sized well beyond one 10 ms period plus setup
    initial begin
        repeat (150000) @(posedge clk_sys);
        mismatches++;
        finish_test();
    end
endmodule : cyclic_wake_timer_test
